// ===== core/rcf_pkg.sv
package rcf_pkg;
  // ****************************************
  // stabilisation wait
  // ****************************************
  localparam int RCF_WAIT_LONG_LOG2 = 17;
  localparam int RCF_WAIT_SHORT_LOG2 = 15;
  localparam int RCF_WAIT_LONG_CYCLES = 2 ** RCF_WAIT_LONG_LOG2;
  localparam int RCF_WAIT_SHORT_CYCLES = 2 ** RCF_WAIT_SHORT_LOG2;
  localparam int RCF_CNT_W = RCF_WAIT_LONG_LOG2 + 1;
  // ****************************************
  // flag reset and set values
  // ****************************************
  localparam logic RCF_WDOG_FLAG_RST = 1'h0;
  localparam logic RCF_KEY_FLAG_RST = 1'h0;
  localparam logic RCF_FLAG_SET = 1'h1;

  typedef enum logic [1:0] {
    RCF_ST_WAIT,
    RCF_ST_RUN
  } rcf_state_t;
endpackage

// ===== core/rcf_reset_cause_flags.sv
module rcf_reset_cause_flags
  import rcf_pkg::*;
#(
  parameter int WAIT_LONG_CYCLES = rcf_pkg::RCF_WAIT_LONG_CYCLES,
  parameter int WAIT_SHORT_CYCLES = rcf_pkg::RCF_WAIT_SHORT_CYCLES,
  parameter bit SHORT_WAIT = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ext_reset,
  input wire logic i_wdog_overflow,
  input wire logic i_key_return_reset,
  input wire logic i_clr_wdog_flag,
  input wire logic i_clr_key_flag,
  output logic o_watchdog_reset_flag,
  output logic o_key_return_reset_flag,
  output logic o_cpu_run
);
  // ****************************************
  // flags
  // ****************************************
  logic wdog_ff, nxt_wdog;
  logic key_ff, nxt_key;
  logic cause_reset;

  // set beats instruction clear so a reset event is never lost
  // ext reset beats set: the pin is the strongest source
  function automatic logic next_flag(
    input logic cur,
    input logic set_evt,
    input logic clr_cmd,
    input logic ext_evt,
    input logic clr_val
  );
    logic nxt;
    nxt = cur;
    if (clr_cmd) begin
      nxt = clr_val;
    end
    if (set_evt) begin
      nxt = RCF_FLAG_SET;
    end
    if (ext_evt) begin
      nxt = clr_val;
    end
    return nxt;
  endfunction

  always_comb begin
    nxt_wdog = next_flag(wdog_ff, i_wdog_overflow, i_clr_wdog_flag, i_ext_reset, RCF_WDOG_FLAG_RST);
    nxt_key = next_flag(key_ff, i_key_return_reset, i_clr_key_flag, i_ext_reset, RCF_KEY_FLAG_RST);
  end

  // i_rst is power-on: flags start clear like an external reset
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wdog_ff <= RCF_WDOG_FLAG_RST;
      key_ff <= RCF_KEY_FLAG_RST;
    end else begin
      wdog_ff <= nxt_wdog;
      key_ff <= nxt_key;
    end
  end

  assign o_watchdog_reset_flag = wdog_ff;
  assign o_key_return_reset_flag = key_ff;
  assign cause_reset = i_ext_reset | i_wdog_overflow | i_key_return_reset;

  // ****************************************
  // stabilisation wait
  // ****************************************
  rcf_wait_timer #(
    .WAIT_LONG_CYCLES(WAIT_LONG_CYCLES),
    .WAIT_SHORT_CYCLES(WAIT_SHORT_CYCLES),
    .SHORT_WAIT(SHORT_WAIT)
  ) u_wait (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_restart(cause_reset),
    .o_run(o_cpu_run)
  );

  // ****************************************
  // run timing model for the checks
  // ****************************************
  // independent count of clocks since the last reset source
  localparam int WAIT_N = SHORT_WAIT ? WAIT_SHORT_CYCLES : WAIT_LONG_CYCLES;
  localparam logic [RCF_CNT_W-1:0] GAP_FULL = RCF_CNT_W'(WAIT_N);
  logic [RCF_CNT_W-1:0] gap_ff, nxt_gap;

  always_comb begin
    nxt_gap = gap_ff;
    if (gap_ff != GAP_FULL) begin
      nxt_gap = gap_ff + 1'b1;
    end
    if (cause_reset) begin
      nxt_gap = '0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      gap_ff <= '0;
    end else begin
      gap_ff <= nxt_gap;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_wdog_set: assert property (@(posedge i_clock) disable iff (i_rst)
    i_wdog_overflow && !i_ext_reset |=> o_watchdog_reset_flag)
    else $error("watchdog flag not set");

  chk_key_set: assert property (@(posedge i_clock) disable iff (i_rst)
    i_key_return_reset && !i_ext_reset |=> o_key_return_reset_flag)
    else $error("key flag not set");

  chk_both_set: assert property (@(posedge i_clock) disable iff (i_rst)
    i_wdog_overflow && i_key_return_reset && !i_ext_reset |=> o_watchdog_reset_flag && o_key_return_reset_flag)
    else $error("simultaneous resets did not set both flags");

  chk_ext_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ext_reset |=> !o_watchdog_reset_flag && !o_key_return_reset_flag)
    else $error("external reset left a flag set");

  chk_wdog_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    o_watchdog_reset_flag && !i_ext_reset && !i_clr_wdog_flag |=> o_watchdog_reset_flag)
    else $error("watchdog flag lost");

  chk_key_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    o_key_return_reset_flag && !i_ext_reset && !i_clr_key_flag |=> o_key_return_reset_flag)
    else $error("key flag lost");

  // power-on reset counts as a clearing event
  chk_only_clears: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(o_watchdog_reset_flag) |-> $past(i_ext_reset) || $past(i_clr_wdog_flag) || $past(i_rst))
    else $error("watchdog flag cleared by other event");

  chk_key_clears: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(o_key_return_reset_flag) |-> $past(i_ext_reset) || $past(i_clr_key_flag) || $past(i_rst))
    else $error("key flag cleared by other event");

  chk_wdog_cause: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_watchdog_reset_flag) |-> $past(i_wdog_overflow))
    else $error("watchdog flag set without overflow");

  chk_key_cause: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_key_return_reset_flag) |-> $past(i_key_return_reset))
    else $error("key flag set without key reset");

  chk_wdog_own: assert property (@(posedge i_clock) disable iff (i_rst)
    i_key_return_reset && !i_wdog_overflow && !i_ext_reset && !i_clr_wdog_flag
      |=> o_watchdog_reset_flag == $past(o_watchdog_reset_flag))
    else $error("key reset disturbed watchdog flag");

  chk_key_own: assert property (@(posedge i_clock) disable iff (i_rst)
    i_wdog_overflow && !i_key_return_reset && !i_ext_reset && !i_clr_key_flag
      |=> o_key_return_reset_flag == $past(o_key_return_reset_flag))
    else $error("watchdog reset disturbed key flag");

  chk_wdog_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clr_wdog_flag && !i_wdog_overflow && !i_ext_reset |=> !o_watchdog_reset_flag)
    else $error("watchdog clear did not clear");

  chk_key_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clr_key_flag && !i_key_return_reset && !i_ext_reset |=> !o_key_return_reset_flag)
    else $error("key clear did not clear");

  chk_clr_own: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clr_key_flag && !i_wdog_overflow && !i_ext_reset && !i_clr_wdog_flag
      |=> o_watchdog_reset_flag == $past(o_watchdog_reset_flag))
    else $error("key clear disturbed watchdog flag");

  chk_clr_wdog_own: assert property (@(posedge i_clock) disable iff (i_rst)
    i_clr_wdog_flag && !i_key_return_reset && !i_ext_reset && !i_clr_key_flag
      |=> o_key_return_reset_flag == $past(o_key_return_reset_flag))
    else $error("watchdog clear disturbed key flag");

  // ****************************************
  // run checks
  // ****************************************
  chk_wait_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    cause_reset |=> !o_cpu_run [*8])
    else $error("run too soon after reset");

  // model restarts on every clock a reset source is high, so it counts from its release
  chk_run_timing: assert property (@(posedge i_clock) disable iff (i_rst)
    o_cpu_run == (gap_ff == GAP_FULL))
    else $error("run not at end of wait");

  chk_run_stays: assert property (@(posedge i_clock) disable iff (i_rst)
    o_cpu_run && !cause_reset |=> o_cpu_run)
    else $error("run dropped without reset");

  chk_ext_run: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ext_reset |=> !o_cpu_run)
    else $error("run kept through external reset");

  chk_run_drop: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(o_cpu_run) |-> $past(cause_reset) || $past(i_rst))
    else $error("run dropped by other event");

  // ****************************************
  // coverage
  // ****************************************
  cov_wdog: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_watchdog_reset_flag));
  cov_key: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_key_return_reset_flag));
  cov_both: cover property (@(posedge i_clock) disable iff (i_rst)
    o_watchdog_reset_flag && o_key_return_reset_flag);
  cov_race: cover property (@(posedge i_clock) disable iff (i_rst)
    i_wdog_overflow && i_clr_wdog_flag);
  cov_run: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_cpu_run));
endmodule

// ===== core/rcf_wait_timer.sv
module rcf_wait_timer
  import rcf_pkg::*;
#(
  parameter int WAIT_LONG_CYCLES = rcf_pkg::RCF_WAIT_LONG_CYCLES,
  parameter int WAIT_SHORT_CYCLES = rcf_pkg::RCF_WAIT_SHORT_CYCLES,
  parameter bit SHORT_WAIT = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_restart,
  output logic o_run
);
  // ****************************************
  // wait counter, restarted by any reset
  // ****************************************
  localparam logic [RCF_CNT_W-1:0] WAIT_LAST = SHORT_WAIT ?
    RCF_CNT_W'(WAIT_SHORT_CYCLES - 1) : RCF_CNT_W'(WAIT_LONG_CYCLES - 1);

  rcf_state_t state_ff, nxt_state;
  logic [rcf_pkg::RCF_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic run_ff, nxt_run;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      RCF_ST_WAIT: begin
        if (cnt_ff == WAIT_LAST) begin
          nxt_state = RCF_ST_RUN;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      RCF_ST_RUN: nxt_state = RCF_ST_RUN;
      default: nxt_state = RCF_ST_WAIT;
    endcase
    if (i_restart) begin
      nxt_state = RCF_ST_WAIT;
      nxt_cnt = '0;
    end
    nxt_run = (nxt_state == RCF_ST_RUN);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_ff <= RCF_ST_WAIT;
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end

  assign o_run = run_ff;
endmodule

// ===== tb/rcf_reset_cause_flags_tb.sv
module rcf_reset_cause_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals and dut
  // ****************************************
  localparam int WAIT_CYC = 16;
  localparam int SHORT_CYC = 12;
  logic o_cpu_run_short;
  logic i_clock;
  logic i_rst;
  logic [4:0] stim;
  logic o_watchdog_reset_flag;
  logic o_key_return_reset_flag;
  logic o_cpu_run;
  int errors;
  int n_checks;
  // short waits keep the run brief
  rcf_reset_cause_flags #(.WAIT_LONG_CYCLES(WAIT_CYC), .WAIT_SHORT_CYCLES(8), .SHORT_WAIT(1'b0)) dut (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ext_reset(stim[4]),
    .i_wdog_overflow(stim[3]),
    .i_key_return_reset(stim[2]),
    .i_clr_wdog_flag(stim[1]),
    .i_clr_key_flag(stim[0]),
    .o_watchdog_reset_flag(o_watchdog_reset_flag),
    .o_key_return_reset_flag(o_key_return_reset_flag),
    .o_cpu_run(o_cpu_run)
  );
  // second copy built with the short wait option
  rcf_reset_cause_flags #(.WAIT_LONG_CYCLES(WAIT_CYC), .WAIT_SHORT_CYCLES(SHORT_CYC), .SHORT_WAIT(1'b1)) dut_short (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ext_reset(stim[4]),
    .i_wdog_overflow(stim[3]),
    .i_key_return_reset(stim[2]),
    .i_clr_wdog_flag(stim[1]),
    .i_clr_key_flag(stim[0]),
    .o_watchdog_reset_flag(),
    .o_key_return_reset_flag(),
    .o_cpu_run(o_cpu_run_short)
  );
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic flags(input logic ew, input logic ek);
    chk("watchdog_reset_flag", ew, o_watchdog_reset_flag);
    chk("key_return_reset_flag", ek, o_key_return_reset_flag);
  endtask
  // one-cycle event, flags sampled a cycle later
  task automatic pulse(input logic [4:0] v);
    @(negedge i_clock);
    stim = v;
    @(negedge i_clock);
    stim = 5'h00;
  endtask
  // entered half a cycle after the last reset edge
  task automatic wait_run();
    repeat (SHORT_CYC - 1) @(negedge i_clock);
    chk("short run early", 1'b0, o_cpu_run_short);
    @(negedge i_clock);
    chk("short run late", 1'b1, o_cpu_run_short);
    repeat (WAIT_CYC - SHORT_CYC - 1) @(negedge i_clock);
    chk("cpu_run early", 1'b0, o_cpu_run);
    @(negedge i_clock);
    chk("cpu_run late", 1'b1, o_cpu_run);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_vals();
    flags(1'b0, 1'b0);
    chk("cpu_run reset", 1'b0, o_cpu_run);
    wait_run();
  endtask
  task automatic t_sources();
    pulse(5'h08);
    flags(1'b1, 1'b0);
    chk("cpu_run restart", 1'b0, o_cpu_run);
    wait_run();
    pulse(5'h04);
    flags(1'b1, 1'b1);
    pulse(5'h08);
    flags(1'b1, 1'b1);
  endtask
  task automatic t_clears();
    pulse(5'h02);
    flags(1'b0, 1'b1);
    pulse(5'h01);
    flags(1'b0, 1'b0);
    pulse(5'h04);
    flags(1'b0, 1'b1);
    pulse(5'h0A);
    flags(1'b1, 1'b1);
  endtask
  task automatic t_ext();
    pulse(5'h1C);
    flags(1'b0, 1'b0);
    wait_run();
  endtask
  // software reads both flags, then clears both
  task automatic t_read_clear();
    pulse(5'h0C);
    flags(1'b1, 1'b1);
    pulse(5'h03);
    flags(1'b0, 1'b0);
  endtask
  // power-on reset during the wait that follows a watchdog reset
  task automatic t_power_reset();
    pulse(5'h08);
    flags(1'b1, 1'b0);
    i_rst = 1'b1;
    @(negedge i_clock);
    i_rst = 1'b0;
    flags(1'b0, 1'b0);
    chk("cpu_run power reset", 1'b0, o_cpu_run);
    wait_run();
  endtask
  task automatic wrap_up();
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************
  // clock, reset, sequence
  // ****************************************
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
  initial begin
    errors = 0;
    n_checks = 0;
    stim = 5'h00;
    i_rst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    t_reset_vals();
    t_sources();
    t_clears();
    t_ext();
    t_read_clear();
    t_power_reset();
    wrap_up();
  end
endmodule
